// ---- hdl/acm_config_manager.sv ----
// Configuration item list, delete mode, host gate and angle display
`default_nettype none
module acm_config_manager
  import acm_pkg::*;
#(
  parameter int unsigned SAT_SLOTS = 16
)
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  // Keypad events, one-cycle pulses
  input  wire logic               key_mode,
  input  wire logic               key_up,
  input  wire logic               key_down,
  input  wire logic               key_enter,
  input  wire logic               erase_key,
  input  wire logic               key_digit,
  input  wire logic [3:0]         key_value,
  input  wire logic               key_minus,
  // Mode selection from the front panel
  input  wire logic               sel_config,
  input  wire logic               sel_delete,
  // Non-volatile storage
  input  wire logic [SAT_SLOTS-1:0] sat_present,
  input  wire logic [15:0]        nv_value,
  input  wire logic               nv_valid,
  output logic                    nv_write,
  output logic [3:0]              nv_item,
  output logic [15:0]             nv_wdata,
  output logic                    sat_erase,
  output logic [$clog2(SAT_SLOTS)-1:0] sat_index,
  // Display
  output logic                    in_config,
  output logic                    in_delete,
  output logic [3:0]              shown_item,
  output logic [15:0]             shown_value,
  output logic                    show_asterisks,
  output logic                    data_deleted,
  output logic [15:0]             entry_value,
  // Live parameters
  output logic                    dual_axis_move_enable,
  output logic                    host_enable,
  output logic                    priv_edit,
  output logic [15:0]             station_address,
  output logic [15:0]             line_rate_code,
  output logic                    line_rate_load,
  output logic [15:0]             pol_scale,
  // Axis motion sequencing
  input  wire logic               move_request,
  output logic                    move_az_el_together,
  // Converter readings (from the converter, another domain)
  input  wire logic [15:0]        az_count_pin,
  input  wire logic [15:0]        el_count_pin,
  input  wire logic [15:0]        pol_count_pin,
  output logic signed [17:0]      az_angle,
  output logic signed [17:0]      el_angle,
  output logic signed [17:0]      pol_angle,
  // Host commands
  input  wire logic               cmd_valid,
  input  wire logic [7:0]         cmd_address,
  input  wire logic               cmd_moves,
  input  wire logic               track_active,
  output logic                    cmd_accept,
  output logic                    enter_host_mode,
  output logic                    stop_track
);
  localparam int unsigned SW = $clog2(SAT_SLOTS);
  typedef enum logic [1:0] {ST_IDLE, ST_CONFIG, ST_DELETE} acm_state_t;

  acm_state_t          state;
  acm_item_t           item;
  logic [2:0]          rev;
  logic signed [15:0]  ofs [3];
  logic [15:0]         entry;
  logic                entry_neg;
  logic [2:0]          entry_len;
  logic [SW-1:0]       sat_sel;
  logic [15:0]         sync1 [3];
  logic [15:0]         sync2 [3];
  logic                priv_now;

  // Reachability of each item
  logic [ITEM_COUNT-1:0] reach;
  assign reach[ITM_DUAL_AXIS]    = 1'b1;
  assign reach[ITM_HOST_EN]      = 1'b1;
  assign reach[ITM_PRIV_EN]      = 1'b1;
  assign reach[ITM_REV_AZ]       = priv_now;
  assign reach[ITM_REV_EL]       = priv_now;
  assign reach[ITM_REV_POL]      = priv_now;
  assign reach[ITM_STATION_ADDR] = priv_now && host_enable;
  assign reach[ITM_LINE_RATE]    = priv_now && host_enable;
  assign reach[ITM_OFS_AZ]       = priv_now;
  assign reach[ITM_OFS_EL]       = priv_now;
  assign reach[ITM_OFS_POL]      = priv_now;
  assign reach[ITM_POL_SCALE]    = priv_now;

  // Next and previous reachable items, wrapping
  function automatic acm_item_t step_item(input acm_item_t cur,
                                          input logic fwd,
                                          input logic [ITEM_COUNT-1:0] r);
    int unsigned k;
    int unsigned idx;
    step_item = cur;
    idx = int'(cur);
    for (k = 0; k < ITEM_COUNT; k++)
    begin
      idx = fwd ? (idx + 1) % ITEM_COUNT : (idx + ITEM_COUNT - 1) % ITEM_COUNT;
      if (r[idx])
      begin
        step_item = acm_item_t'(idx[3:0]);
        break;
      end
    end
  endfunction

  // Signed entry and its range check
  logic signed [15:0] entry_s;
  logic               rate_ok;
  logic               accept;
  assign entry_s = entry_neg ? 16'(-$signed(entry)) : $signed(entry);
  assign rate_ok = (entry == 16'h0003) || (entry == 16'h0006) ||
                   (entry == 16'h000C) || (entry == 16'h0018) ||
                   (entry == 16'h0030) || (entry == 16'h0060);
  always_comb
  begin
    accept = 1'b0;
    unique case (item)
      ITM_DUAL_AXIS, ITM_HOST_EN, ITM_PRIV_EN, ITM_REV_AZ, ITM_REV_EL,
      ITM_REV_POL:
        accept = !entry_neg && entry <= 16'h0001;
      ITM_STATION_ADDR:
        accept = !entry_neg && entry >= ADDR_MIN && entry <= ADDR_MAX;
      ITM_LINE_RATE:
        accept = !entry_neg && rate_ok;
      ITM_OFS_AZ, ITM_OFS_EL, ITM_OFS_POL:
        accept = entry_s >= OFS_MIN && entry_s <= OFS_MAX;
      ITM_POL_SCALE:
        accept = !entry_neg && entry >= SCALE_MIN && entry <= SCALE_MAX;
      default:
        accept = 1'b0;
    endcase
  end

  logic commit;
  assign commit = (state == ST_CONFIG) && key_enter && entry_len != 0 &&
                  !key_mode && accept;
  // Advance after a flag change must use the new flag, not the old one
  assign priv_now = (commit && item == ITM_PRIV_EN) ? entry[0] :
                    priv_edit;

  // Current value of the shown item
  always_comb
  begin
    shown_value = 16'h0000;
    unique case (item)
      ITM_DUAL_AXIS:    shown_value = {15'h0000, dual_axis_move_enable};
      ITM_HOST_EN:      shown_value = {15'h0000, host_enable};
      ITM_PRIV_EN:      shown_value = {15'h0000, priv_edit};
      ITM_REV_AZ:       shown_value = {15'h0000, rev[0]};
      ITM_REV_EL:       shown_value = {15'h0000, rev[1]};
      ITM_REV_POL:      shown_value = {15'h0000, rev[2]};
      ITM_STATION_ADDR: shown_value = station_address;
      ITM_LINE_RATE:    shown_value = line_rate_code;
      ITM_OFS_AZ:       shown_value = ofs[0];
      ITM_OFS_EL:       shown_value = ofs[1];
      ITM_OFS_POL:      shown_value = ofs[2];
      ITM_POL_SCALE:    shown_value = pol_scale;
      default:          shown_value = 16'h0000;
    endcase
  end

  assign in_config = (state == ST_CONFIG);
  assign in_delete = (state == ST_DELETE);
  assign shown_item = item;
  assign entry_value = entry_s;
  assign show_asterisks = in_config && !nv_valid && entry_len == 0;
  assign nv_item = item;
  assign sat_index = sat_sel;
  assign move_az_el_together = move_request && dual_axis_move_enable;

  // Front panel state
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      state <= ST_IDLE;
    else if (key_mode)
      state <= ST_IDLE;
    else if (state == ST_IDLE && sel_config)
      state <= ST_CONFIG;
    else if (state == ST_IDLE && sel_delete && priv_edit)
      state <= ST_DELETE;
  end

  // Item walk and keyed entry
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      item      <= ITM_DUAL_AXIS;
      entry     <= '0;
      entry_neg <= 1'b0;
      entry_len <= '0;
    end
    else if (state != ST_CONFIG || key_mode)
    begin
      item      <= ITM_DUAL_AXIS;
      entry     <= '0;
      entry_neg <= 1'b0;
      entry_len <= '0;
    end
    else if (key_enter)
    begin
      entry     <= '0;
      entry_neg <= 1'b0;
      entry_len <= '0;
      if (commit)
        item <= step_item(item, 1'b1, reach);
    end
    else if (erase_key && entry_len != 0)
    begin
      entry     <= 16'(entry / 16'd10);
      entry_len <= entry_len - 3'd1;
    end
    else if (key_digit && entry_len < 3'(ENTRY_DIGITS))
    begin
      entry     <= 16'(entry * 16'd10 + 16'(key_value));
      entry_len <= entry_len + 3'd1;
    end
    else if (key_minus && entry_len == 0)
      entry_neg <= ~entry_neg;
    else if (key_up || key_down)
      item <= step_item(item, key_up, reach);
  end

  // Live parameters, changed only on accepted entries
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dual_axis_move_enable <= 1'b0;
      host_enable           <= 1'b0;
      priv_edit             <= 1'b0;
      rev                   <= '0;
      station_address       <= ADDR_RST;
      line_rate_code        <= RATE_RST;
      pol_scale             <= SCALE_RST;
      ofs[0]                <= '0;
      ofs[1]                <= '0;
      ofs[2]                <= '0;
    end
    else if (commit)
    begin
      unique case (item)
        ITM_DUAL_AXIS:    dual_axis_move_enable <= entry[0];
        ITM_HOST_EN:      host_enable <= entry[0];
        ITM_PRIV_EN:      priv_edit <= entry[0];
        ITM_REV_AZ:       rev[0] <= entry[0];
        ITM_REV_EL:       rev[1] <= entry[0];
        ITM_REV_POL:      rev[2] <= entry[0];
        ITM_STATION_ADDR: station_address <= entry;
        ITM_LINE_RATE:    line_rate_code <= entry;
        ITM_OFS_AZ:       ofs[0] <= entry_s;
        ITM_OFS_EL:       ofs[1] <= entry_s;
        ITM_OFS_POL:      ofs[2] <= entry_s;
        ITM_POL_SCALE:    pol_scale <= entry;
        default:          pol_scale <= pol_scale;
      endcase
    end
  end

  // Storage write and rate reload are registered from commit, on the same edge as the live update
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      nv_write       <= 1'b0;
      nv_wdata       <= '0;
      line_rate_load <= 1'b0;
    end
    else
    begin
      nv_write       <= commit;
      nv_wdata       <= commit ? entry_s : nv_wdata;
      line_rate_load <= commit && item == ITM_LINE_RATE;
    end
  end

  // Delete mode: scroll occupied slots, erase on enter
  logic [SW-1:0] next_up;
  logic [SW-1:0] next_dn;
  always_comb
  begin
    next_up = sat_sel;
    next_dn = sat_sel;
    for (int k = SAT_SLOTS - 1; k >= 1; k--)
    begin
      if (sat_present[SW'((32'(sat_sel) + k) % SAT_SLOTS)])
        next_up = SW'((32'(sat_sel) + k) % SAT_SLOTS);
      if (sat_present[SW'((32'(sat_sel) + SAT_SLOTS - k) % SAT_SLOTS)])
        next_dn = SW'((32'(sat_sel) + SAT_SLOTS - k) % SAT_SLOTS);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sat_sel      <= '0;
      sat_erase    <= 1'b0;
      data_deleted <= 1'b0;
    end
    else
    begin
      sat_erase <= in_delete && key_enter && sat_present[sat_sel];
      if (in_delete && key_enter && sat_present[sat_sel])
        data_deleted <= 1'b1;
      else if (key_mode || !in_delete || key_up || key_down)
        data_deleted <= 1'b0;
      if (in_delete && key_up)
        sat_sel <= next_up;
      else if (in_delete && key_down)
        sat_sel <= next_dn;
    end
  end

  // Converter words come from outside: two flops before use
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int a = 0; a < 3; a++)
      begin
        sync1[a] <= '0;
        sync2[a] <= '0;
      end
    end
    else
    begin
      sync1[0] <= az_count_pin;
      sync1[1] <= el_count_pin;
      sync1[2] <= pol_count_pin;
      for (int a = 0; a < 3; a++)
        sync2[a] <= sync1[a];
    end
  end

  acm_angle_conv #(.SIGNED_SPAN(1'b0)) u_az (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .count   (sync2[0]),
    .reverse (rev[0]),
    .offset  (ofs[0]),
    .angle   (az_angle)
  );
  acm_angle_conv #(.SIGNED_SPAN(1'b1)) u_el (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .count   (sync2[1]),
    .reverse (rev[1]),
    .offset  (ofs[1]),
    .angle   (el_angle)
  );
  acm_angle_conv #(.SIGNED_SPAN(1'b1)) u_pol (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .count   (sync2[2]),
    .reverse (rev[2]),
    .offset  (ofs[2]),
    .angle   (pol_angle)
  );

  acm_cmd_filter u_cmd (
    .sys_clk         (sys_clk),
    .nrst            (nrst),
    .host_enable     (host_enable),
    .station_address (station_address),
    .cmd_valid       (cmd_valid),
    .cmd_address     (cmd_address),
    .cmd_moves       (cmd_moves),
    .track_active    (track_active),
    .cmd_accept      (cmd_accept),
    .enter_host_mode (enter_host_mode),
    .stop_track      (stop_track)
  );
endmodule // acm_config_manager
`default_nettype wire

// ---- hdl/acm_pkg.sv ----
// Package of constants and types for the antenna configuration manager
`default_nettype none
package acm_pkg;
  // Item list order
  typedef enum logic [3:0] {
    ITM_DUAL_AXIS, ITM_HOST_EN, ITM_PRIV_EN, ITM_REV_AZ, ITM_REV_EL,
    ITM_REV_POL, ITM_STATION_ADDR, ITM_LINE_RATE, ITM_OFS_AZ, ITM_OFS_EL,
    ITM_OFS_POL, ITM_POL_SCALE
  } acm_item_t;
  localparam int unsigned ITEM_COUNT = 12;
  // Operating modes; the command filter does not use them and sees only track_active
  typedef enum logic [1:0] {
    OPM_LOCAL, OPM_TRACK, OPM_HOST
  } acm_opmode_t;
  // Value limits (offsets in hundredths of a degree)
  localparam logic [15:0] ADDR_MIN   = 16'h0031;
  localparam logic [15:0] ADDR_MAX   = 16'h006F;
  localparam logic [15:0] SCALE_MIN  = 16'h0005;
  localparam logic [15:0] SCALE_MAX  = 16'h0064;
  localparam logic signed [15:0] OFS_MIN = -16'sd17999;
  localparam logic signed [15:0] OFS_MAX = 16'sd18000;
  // Reset values of the live parameters
  localparam logic [15:0] ADDR_RST   = 16'h0032;
  localparam logic [15:0] RATE_RST   = 16'h0060;
  localparam logic [15:0] SCALE_RST  = 16'h0032;
  // Angle conversion: 36000 hundredths over 65536 counts
  localparam logic [31:0] DEG100_FULL = 32'h00008CA0;
  localparam int unsigned CNT_SHIFT   = 16;
  localparam logic signed [17:0] EL_WRAP = 18'sd26000;
  localparam logic signed [17:0] FULL_TURN = 18'sd36000;
  // Keyed entry digits
  localparam int unsigned ENTRY_DIGITS = 6;
endpackage : acm_pkg
`default_nettype wire

// ---- hdl/acm_angle_conv.sv ----
// Converter count to displayed angle for one axis
`default_nettype none
module acm_angle_conv
  import acm_pkg::*;
#(
  parameter bit SIGNED_SPAN = 1'b0
)
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  // Reading and setup
  input  wire logic [15:0]        count,
  input  wire logic               reverse,
  input  wire logic signed [15:0] offset,
  // Result in hundredths of a degree
  output logic signed [17:0]      angle
);
  logic [15:0]        dir_count;
  logic [31:0]        product;
  logic signed [17:0] base;
  logic signed [17:0] summed;
  logic signed [17:0] wrapped;

  // Reverse turns a rising count into a falling one
  assign dir_count = reverse ? 16'(16'h0000 - count) : count;
  assign product = 32'(dir_count) * DEG100_FULL;
  assign base = 18'($signed({2'b00, product[31:CNT_SHIFT]}));
  assign summed = base + 18'(offset);
  // Fold into the displayed span of the axis
  assign wrapped = (summed < 0) ? summed + FULL_TURN :
                   (summed >= FULL_TURN) ? summed - FULL_TURN : summed;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      angle <= '0;
    else if (SIGNED_SPAN && wrapped > EL_WRAP)
      angle <= wrapped - FULL_TURN;
    else
      angle <= wrapped;
  end
endmodule // acm_angle_conv
`default_nettype wire

// ---- hdl/acm_cmd_filter.sv ----
// Addressed host command acceptance and mode steering
`default_nettype none
module acm_cmd_filter
  import acm_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Setup
  input  wire logic        host_enable,
  input  wire logic [15:0] station_address,
  // Decoded command
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_address,
  input  wire logic        cmd_moves,
  input  wire logic        track_active,
  // Results
  output logic             cmd_accept,
  output logic             enter_host_mode,
  output logic             stop_track
);
  logic addr_match;
  logic take;

  assign addr_match = ({8'h00, cmd_address} == station_address);
  assign take = cmd_valid && host_enable && addr_match;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmd_accept      <= 1'b0;
      enter_host_mode <= 1'b0;
      stop_track      <= 1'b0;
    end
    else
    begin
      cmd_accept      <= take;
      enter_host_mode <= take && (!track_active || cmd_moves);
      stop_track      <= take && track_active && cmd_moves;
    end
  end
endmodule // acm_cmd_filter
`default_nettype wire

// ---- dv/acm_config_manager_asserts.sv ----
// Port-level checker of the configuration manager
`default_nettype none
module acm_config_manager_asserts
  import acm_pkg::*;
#(
  parameter int unsigned SAT_SLOTS = 16
)
(
  // Clock and reset
  input wire logic                         sys_clk,
  input wire logic                         nrst,
  // Keys and storage
  input wire logic                         key_mode,
  input wire logic                         key_enter,
  input wire logic [SAT_SLOTS-1:0]         sat_present,
  input wire logic                         nv_valid,
  input wire logic                         nv_write,
  input wire logic                         sat_erase,
  input wire logic [$clog2(SAT_SLOTS)-1:0] sat_index,
  // Display
  input wire logic                         in_config,
  input wire logic                         in_delete,
  input wire logic [3:0]                   shown_item,
  input wire logic                         show_asterisks,
  input wire logic                         data_deleted,
  // Live parameters
  input wire logic                         dual_axis_move_enable,
  input wire logic                         host_enable,
  input wire logic                         priv_edit,
  input wire logic [15:0]                  station_address,
  input wire logic [15:0]                  line_rate_code,
  input wire logic                         line_rate_load,
  input wire logic [15:0]                  pol_scale,
  input wire logic                         move_request,
  input wire logic                         move_az_el_together,
  // Host commands
  input wire logic                         cmd_valid,
  input wire logic [7:0]                   cmd_address,
  input wire logic                         cmd_moves,
  input wire logic                         track_active,
  input wire logic                         cmd_accept,
  input wire logic                         enter_host_mode,
  input wire logic                         stop_track
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_hit;
    cmd_valid && host_enable && station_address == {8'h00, cmd_address};
  endsequence
  sequence s_miss;
    cmd_valid && !(host_enable && station_address == {8'h00, cmd_address});
  endsequence
  priv_gate_a: assert property (
    in_config && !priv_edit |-> shown_item <= 4'h2)
    else $error("locked item shown");
  host_gate_a: assert property (
    in_config && !host_enable |-> shown_item != ITM_STATION_ADDR
      && shown_item != ITM_LINE_RATE)
    else $error("host link item shown while disabled");
  mode_exit_a: assert property (
    key_mode && in_config |=> !in_config)
    else $error("mode key did not leave item list");
  enter_only_a: assert property (
    nv_write |-> $past(key_enter))
    else $error("store without enter");
  addr_range_a: assert property (
    station_address >= ADDR_MIN && station_address <= ADDR_MAX)
    else $error("station address out of range");
  rate_set_a: assert property (
    line_rate_load |-> line_rate_code inside {16'h0003, 16'h0006,
      16'h000C, 16'h0018, 16'h0030, 16'h0060})
    else $error("illegal line rate loaded");
  scale_range_a: assert property (
    pol_scale >= SCALE_MIN && pol_scale <= SCALE_MAX)
    else $error("scale factor out of range");
  asterisk_fill_a: assert property (
    show_asterisks |-> in_config && !nv_valid)
    else $error("asterisks without invalid value");
  delete_gate_a: assert property (
    $rose(in_delete) |-> priv_edit)
    else $error("delete entered without privilege");
  erase_slot_a: assert property (
    sat_erase |-> sat_present[sat_index] ##[0:1] data_deleted)
    else $error("erase of empty slot or no report");
  cmd_match_a: assert property (
    s_hit |=> cmd_accept)
    else $error("addressed command not accepted");
  cmd_ignore_a: assert property (
    s_miss |=> !cmd_accept && !enter_host_mode && !stop_track)
    else $error("foreign command acted on");
  host_mode_a: assert property (
    s_hit |=> enter_host_mode == (!$past(track_active) || $past(cmd_moves))
      && stop_track == ($past(track_active) && $past(cmd_moves)))
    else $error("wrong mode steering");
  together_a: assert property (
    move_az_el_together == (move_request && dual_axis_move_enable))
    else $error("axis sequencing wrong");
endmodule // acm_config_manager_asserts
bind acm_config_manager acm_config_manager_asserts
  #(.SAT_SLOTS(SAT_SLOTS)) acm_config_manager_asserts_inst (
  .sys_clk, .nrst, .key_mode, .key_enter, .sat_present, .nv_valid,
  .nv_write, .sat_erase, .sat_index, .in_config, .in_delete, .shown_item,
  .show_asterisks, .data_deleted, .dual_axis_move_enable, .host_enable,
  .priv_edit, .station_address, .line_rate_code, .line_rate_load,
  .pol_scale, .move_request, .move_az_el_together, .cmd_valid,
  .cmd_address, .cmd_moves, .track_active, .cmd_accept, .enter_host_mode,
  .stop_track);
`default_nettype wire

// ---- dv/acm_host_model.sv ----
// Remote host stand-in issuing addressed commands
`default_nettype none
module acm_host_model
(
  // Clock
  input  wire logic      sys_clk,
  // Decoded command towards the device
  output var logic       cmd_valid,
  output var logic [7:0] cmd_address,
  output var logic       cmd_moves
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    cmd_valid = 1'b0;
    cmd_address = 8'h00;
    cmd_moves = 1'b0;
  end
  // Caller passes the address to send, the configured station value or a foreign one
  task automatic send(input logic [7:0] addr, input logic moves);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_address = addr;
    cmd_moves = moves;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    // Idle lines carry junk so a stale value never looks valid
    cmd_address = ~addr;
    cmd_moves = ~moves;
  endtask
endmodule // acm_host_model
`default_nettype wire

// ---- dv/acm_config_manager_bench.sv ----
// Self-checking bench of the configuration manager
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
module acm_config_manager_bench import acm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic               sys_clk, nrst, key_mode, key_up, key_down, key_enter;
  logic               erase_key, key_digit, key_minus, sel_config;
  logic               sel_delete, nv_valid, move_request, track_active;
  logic               nv_write, sat_erase, in_config, in_delete;
  logic               show_asterisks, data_deleted, dual_axis_move_enable;
  logic               host_enable, priv_edit, line_rate_load, cmd_valid;
  logic               move_az_el_together, cmd_moves, cmd_accept;
  logic               enter_host_mode, stop_track;
  logic [3:0]         key_value, nv_item, shown_item, sat_index;
  logic [7:0]         cmd_address;
  logic [15:0]        sat_present, nv_value, az_count_pin, el_count_pin;
  logic [15:0]        pol_count_pin, nv_wdata, shown_value, entry_value;
  logic [15:0]        station_address, line_rate_code, pol_scale;
  logic signed [17:0] az_angle, el_angle, pol_angle;
  int                 n_mismatch, num_checks, n_nv, n_acc, n_host;
  int                 n_stop, n_era, n_load;
  logic [15:0]        codes [6] = '{16'h0003, 16'h0006, 16'h000C,
                                    16'h0018, 16'h0030, 16'h0060};
  acm_config_manager #(.SAT_SLOTS(16)) acm_config_manager_inst (
    .sys_clk, .nrst, .key_mode, .key_up, .key_down, .key_enter, .erase_key,
    .key_digit, .key_value, .key_minus, .sel_config, .sel_delete,
    .sat_present, .nv_value, .nv_valid, .nv_write, .nv_item, .nv_wdata,
    .sat_erase, .sat_index, .in_config, .in_delete, .shown_item,
    .shown_value, .show_asterisks, .data_deleted, .entry_value,
    .dual_axis_move_enable, .host_enable, .priv_edit, .station_address,
    .line_rate_code, .line_rate_load, .pol_scale, .move_request,
    .move_az_el_together, .az_count_pin, .el_count_pin, .pol_count_pin,
    .az_angle, .el_angle, .pol_angle, .cmd_valid, .cmd_address, .cmd_moves,
    .track_active, .cmd_accept, .enter_host_mode, .stop_track);
  acm_host_model acm_host_model_inst (
    .sys_clk, .cmd_valid, .cmd_address, .cmd_moves);
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Pulse counters make checks immune to exact answer latency
  always @(posedge sys_clk)
  begin
    n_nv += nv_write;
    n_acc += cmd_accept;
    n_host += enter_host_mode;
    n_stop += stop_track;
    n_era += sat_erase;
    n_load += line_rate_load;
  end
  task automatic final_report;
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic press(ref logic k);
    @(negedge sys_clk);
    k = 1'b1;
    @(negedge sys_clk);
    k = 1'b0;
  endtask
  task automatic dig(input int d);
    key_value = d[3:0];
    press(key_digit);
  endtask
  task automatic entry(input int v);
    int m;
    int p;
    m = (v < 0) ? -v : v;
    if (v < 0)
      press(key_minus);
    for (p = 1; p * 10 <= m; p *= 10);
    for (; p > 0; p /= 10)
      dig((m / p) % 10);
    press(key_enter);
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic acc(input int v, input int nv_exp, input logic [3:0] it);
    entry(v);
    `CHK(n_nv, nv_exp)
    `CHK(shown_item, it)
  endtask
  initial
  begin
    #1000000;
    n_mismatch++;
    final_report;
  end
  initial
  begin
    nrst = 1'b0;
    {key_mode, key_up, key_down, key_enter, erase_key, key_digit} = '0;
    {key_minus, sel_config, sel_delete, move_request, track_active} = '0;
    {key_value, sat_present, nv_value} = '0;
    {az_count_pin, el_count_pin, pol_count_pin, nv_valid} = 49'h1;
    repeat (8) @(negedge sys_clk);
    nrst = 1'b1;
    `CHK(station_address, ADDR_RST)
    `CHK(line_rate_code, RATE_RST)
    `CHK(pol_scale, SCALE_RST)
    move_request = 1'b1;
    #1 `CHK(move_az_el_together, 1'b0)
    press(sel_delete);
    @(negedge sys_clk);
    `CHK(in_delete, 1'b0)
    acm_host_model_inst.send(8'h32, 1'b0);
    @(negedge sys_clk);
    `CHK(n_acc, 0)
    press(sel_config);
    nv_valid = 1'b0;
    @(negedge sys_clk);
    `CHK(show_asterisks, 1'b1)
    nv_valid = 1'b1;
    repeat (3) press(key_up);
    `CHK(shown_item, ITM_DUAL_AXIS)
    repeat (3) press(key_down);
    `CHK(shown_item, ITM_DUAL_AXIS)
    acc(1, 1, ITM_HOST_EN);
    `CHK(move_az_el_together, 1'b1)
    acc(1, 2, ITM_PRIV_EN);
    press(key_enter);
    acc(2, 2, ITM_PRIV_EN);
    acc(1, 3, ITM_REV_AZ);
    repeat (12) press(key_up);
    `CHK(shown_item, ITM_REV_AZ)
    press(key_up);
    `CHK(shown_item, ITM_REV_EL)
    press(key_down);
    acc(1, 4, ITM_REV_EL);
    acc(0, 5, ITM_REV_POL);
    acc(0, 6, ITM_STATION_ADDR);
    acc(112, 6, ITM_STATION_ADDR);
    acc(48, 6, ITM_STATION_ADDR);
    acc(49, 7, ITM_LINE_RATE);
    `CHK(station_address, 16'h0031)
    acc(5, 7, ITM_LINE_RATE);
    acc(97, 7, ITM_LINE_RATE);
    foreach (codes[i])
    begin
      acc(codes[i], 8 + i, ITM_OFS_AZ);
      `CHK(line_rate_code, codes[i])
      `CHK(n_load, i + 1)
      if (i < 5)
        press(key_down);
    end
    dig(4);
    dig(5);
    press(erase_key);
    acc(-1, 14, ITM_OFS_EL);
    acc(18001, 14, ITM_OFS_EL);
    acc(0, 15, ITM_OFS_POL);
    acc(-100, 16, ITM_POL_SCALE);
    acc(4, 16, ITM_POL_SCALE);
    acc(101, 16, ITM_POL_SCALE);
    entry(100);
    `CHK(pol_scale, 16'h0064)
    az_count_pin = 16'h4000;
    el_count_pin = 16'hC000;
    pol_count_pin = 16'h2000;
    repeat (5) @(negedge sys_clk);
    `CHK(az_angle, 18'h069A1)
    `CHK(el_angle, 18'h3DCD8)
    `CHK(pol_angle, 18'h01130)
    dig(7);
    press(key_mode);
    `CHK(in_config, 1'b0)
    `CHK(n_nv, 17)
    sat_present = 16'h0024;
    press(sel_delete);
    @(negedge sys_clk);
    `CHK(in_delete, 1'b1)
    press(key_up);
    press(key_enter);
    @(negedge sys_clk);
    `CHK(n_era, 1)
    `CHK(data_deleted, 1'b1)
    `CHK(sat_present[sat_index], 1'b1)
    sat_present[sat_index] = 1'b0;
    press(key_up);
    `CHK(data_deleted, 1'b0)
    press(key_mode);
    acm_host_model_inst.send(8'h32, 1'b0);
    acm_host_model_inst.send(8'h31, 1'b0);
    track_active = 1'b1;
    acm_host_model_inst.send(8'h31, 1'b0);
    acm_host_model_inst.send(8'h31, 1'b1);
    @(negedge sys_clk);
    `CHK(n_acc, 3)
    `CHK(n_host, 2)
    `CHK(n_stop, 1)
    final_report;
  end
endmodule // acm_config_manager_bench
`default_nettype wire
